// ===== rtl/pin_sync.sv
// two-flop synchroniser for a group of socket pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // pins and synchronised copy
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end

    assign pin_out = sync_reg;
endmodule // pin_sync
`default_nettype wire

// ===== rtl/sock_regs_pkg.sv
// constants shared by the socket status and mask register block
package sock_regs_pkg;
    localparam logic [7:0] OFS_EVENT = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_STATE = 8'h08;
    localparam logic [7:0] OFS_FORCE = 8'h0c;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam int MASK_WIDTH = 4;
    localparam int EVT_WIDTH = 4;
    localparam int BIT_CSTS = 0;
    localparam int BIT_CD1 = 1;
    localparam int BIT_CD2 = 2;
    localparam int BIT_PWR = 3;
    localparam int BIT_READY = 6;
    localparam int BIT_CARD3V = 11;
    localparam int BIT_CARDXV = 12;
    localparam int BIT_CARDYV = 13;
    localparam int BIT_ZV = 27;
    localparam int BIT_SOCK5V = 28;
    localparam int BIT_SOCK3V = 29;
    localparam int BIT_SOCKXV = 30;
    localparam int BIT_SOCKYV = 31;
    localparam logic [3:0] SOCK_SUPPLY_RESET = 4'h3;
    localparam logic [1:0] CD_ENABLED = 2'h3;
endpackage : sock_regs_pkg

// ===== rtl/socket_status_mask_regs.sv
// socket event, mask, present-state and force-event registers of one card socket
`timescale 1ns/1ns
`default_nettype none
// Function
// - event flags set regardless of mask bits
// - mask bits 31..4 read zero
// - mask bit 3 gates power-cycle interrupt
// - mask bits 2..1 gate card-detect interrupt
// - mask bit 0 gates card-status interrupt
// - present-state bits 27 and 13..11 reflect force-event writes
// - card voltage fields update on insertion or on a force-event write
// - detect pins frozen during card identification
// - bits 31,30 always read zero, force-event writes leave them
// - bits 29,28 always read one, force-event writes leave them
// - bit 27 reports zoomed-video capability
// - present-state bits 26..14 read zero
// - bits 13..11 report card voltage support
// - reset value 3000_00xx with pin bits
// - event set on change, cleared writing one
// - status edge: rising 32-bit, both 16-bit
// - detect bit follows synchronised pin level outside card identification
module socket_status_mask_regs
    import sock_regs_pkg::*;
#(
    parameter logic ZV_CAPABLE = 1'b0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // socket pins
    input wire logic card_detect_pin_one,
    input wire logic card_detect_pin_two,
    input wire logic card_status_change_pin,
    input wire logic ready_pin,
    // socket state from the rest of the bridge
    input wire logic socket_powered_flag,
    input wire logic card_is_cardbus,
    input wire logic card_identifying,
    input wire logic card_inserted_pulse,
    input wire logic [2:0] card_volt_sense,
    // interrupt
    output logic status_change_interrupt
);
    logic [3:0] pins_sync;
    logic [3:0] mask_reg, mask_next;
    logic [3:0] event_reg, event_next;
    logic [3:0] sock_supply_reg, sock_supply_next;
    logic zoomed_video_capable_reg, zoomed_video_capable_next;
    logic [2:0] card_volt_reg, card_volt_next;
    logic detect_pin_one_state_reg, detect_pin_one_state_next;
    logic detect_pin_two_state_reg, detect_pin_two_state_next;
    logic card_status_pin_state_reg, card_status_pin_state_next;
    logic power_reg, power_next;
    logic ready_reg, ready_next;
    logic [31:0] rdata_reg, rdata_next;
    logic irq_reg, irq_next;
    logic power_cycle_irq_enable;
    logic [1:0] card_detect_irq_enable;
    logic card_status_irq_enable;
    logic wr_mask, wr_event, wr_force;
    logic [3:0] hw_set;
    logic [3:0] enables;
    logic [31:0] state_word;

    pin_sync #(.WIDTH(4)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .pin_in({ready_pin, card_status_change_pin, card_detect_pin_two, card_detect_pin_one}),
        .pin_out(pins_sync)
    );

    assign power_cycle_irq_enable = mask_reg[BIT_PWR];
    assign card_detect_irq_enable = mask_reg[BIT_CD2:BIT_CD1];
    assign card_status_irq_enable = mask_reg[BIT_CSTS];
    assign wr_mask = reg_wr && (reg_addr == OFS_MASK);
    assign wr_event = reg_wr && (reg_addr == OFS_EVENT);
    assign wr_force = reg_wr && (reg_addr == OFS_FORCE);

    always_comb begin
        state_word = '0;
        state_word[BIT_SOCKYV] = sock_supply_reg[3];
        state_word[BIT_SOCKXV] = sock_supply_reg[2];
        state_word[BIT_SOCK3V] = sock_supply_reg[1];
        state_word[BIT_SOCK5V] = sock_supply_reg[0];
        state_word[BIT_ZV] = zoomed_video_capable_reg;
        state_word[BIT_CARDYV:BIT_CARD3V] = card_volt_reg;
        state_word[BIT_READY] = ready_reg;
        state_word[BIT_PWR] = power_reg;
        state_word[BIT_CD2] = detect_pin_two_state_reg;
        state_word[BIT_CD1] = detect_pin_one_state_reg;
        state_word[BIT_CSTS] = card_status_pin_state_reg;
    end

    // live socket state and forced overrides
    always_comb begin
        sock_supply_next = sock_supply_reg;
        zoomed_video_capable_next = zoomed_video_capable_reg;
        card_volt_next = card_volt_reg;
        detect_pin_one_state_next = detect_pin_one_state_reg;
        detect_pin_two_state_next = detect_pin_two_state_reg;
        card_status_pin_state_next = pins_sync[2];
        power_next = socket_powered_flag;
        ready_next = pins_sync[3];
        if (!card_identifying) begin
            detect_pin_one_state_next = pins_sync[0];
            detect_pin_two_state_next = pins_sync[1];
        end
        if (card_inserted_pulse) begin
            card_volt_next = card_volt_sense;
        end
        if (wr_force) begin
            card_volt_next = reg_wdata[BIT_CARDYV:BIT_CARD3V];
            zoomed_video_capable_next = reg_wdata[BIT_ZV];
        end
    end

    // event flags, mask register and interrupt
    always_comb begin
        hw_set = '0;
        hw_set[BIT_PWR] = power_next != power_reg;
        hw_set[BIT_CD1] = detect_pin_one_state_next != detect_pin_one_state_reg;
        hw_set[BIT_CD2] = detect_pin_two_state_next != detect_pin_two_state_reg;
        if (card_is_cardbus) begin
            hw_set[BIT_CSTS] = card_status_pin_state_next && !card_status_pin_state_reg;
        end else begin
            hw_set[BIT_CSTS] = card_status_pin_state_next != card_status_pin_state_reg;
        end
        event_next = event_reg;
        if (wr_event) begin
            event_next = event_next & ~reg_wdata[EVT_WIDTH-1:0];
        end
        if (wr_force) begin
            event_next = event_next | reg_wdata[EVT_WIDTH-1:0];
        end
        event_next = event_next | hw_set;
        mask_next = mask_reg;
        if (wr_mask) begin
            mask_next = reg_wdata[MASK_WIDTH-1:0];
        end
        enables[BIT_PWR] = power_cycle_irq_enable;
        enables[BIT_CD1] = card_detect_irq_enable == CD_ENABLED;
        enables[BIT_CD2] = card_detect_irq_enable == CD_ENABLED;
        enables[BIT_CSTS] = card_status_irq_enable;
        irq_next = |(event_reg & enables);
    end

    // read data
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            case (reg_addr)
                OFS_EVENT: rdata_next = {28'h0, event_reg};
                OFS_MASK: rdata_next = {28'h0, mask_reg};
                OFS_STATE: rdata_next = state_word;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mask_reg <= MASK_RESET[MASK_WIDTH-1:0];
            event_reg <= '0;
            sock_supply_reg <= SOCK_SUPPLY_RESET;
            zoomed_video_capable_reg <= ZV_CAPABLE;
            card_volt_reg <= '0;
            detect_pin_one_state_reg <= 1'b0;
            detect_pin_two_state_reg <= 1'b0;
            card_status_pin_state_reg <= 1'b0;
            power_reg <= 1'b0;
            ready_reg <= 1'b0;
            rdata_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            mask_reg <= mask_next;
            event_reg <= event_next;
            sock_supply_reg <= sock_supply_next;
            zoomed_video_capable_reg <= zoomed_video_capable_next;
            card_volt_reg <= card_volt_next;
            detect_pin_one_state_reg <= detect_pin_one_state_next;
            detect_pin_two_state_reg <= detect_pin_two_state_next;
            card_status_pin_state_reg <= card_status_pin_state_next;
            power_reg <= power_next;
            ready_reg <= ready_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign status_change_interrupt = irq_reg;
endmodule // socket_status_mask_regs
`default_nettype wire

// ===== test/card_model.sv
// card in the socket: detect, status, ready and sense lines
`timescale 1ns/1ns
`default_nettype none
module card_model (
    // commands from the bench
    input wire logic mclk, present, csts, rdy,
    input wire logic [2:0] volt,
    // socket pins
    output logic card_detect_pin_one = 1'b1, card_detect_pin_two = 1'b1,
    output logic card_status_change_pin = 1'b0, ready_pin = 1'b0,
    output logic [2:0] card_volt_sense = 3'h0
);
    always @(posedge mclk) begin
        card_detect_pin_one <= !present;
        card_detect_pin_two <= !present;
        card_status_change_pin <= present & csts;
        ready_pin <= present & rdy;
        card_volt_sense <= present ? volt : ~card_volt_sense;
    end
endmodule // card_model
`default_nettype wire

// ===== test/socket_status_mask_regs_properties.sv
// port checks for the socket register block
`timescale 1ns/1ns
`default_nettype none
module socket_status_mask_regs_properties (
    // clock, reset, register port
    input wire logic mclk, rst, reg_wr, reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata, reg_rdata,
    // socket side, interrupt
    input wire logic card_detect_pin_one, card_status_change_pin, socket_powered_flag,
    input wire logic card_is_cardbus, card_identifying, status_change_interrupt
);
    logic [3:0] m_reg, m_next;
    logic rd_st;
    assign rd_st = reg_rd && reg_addr == 8'h08;
    always_comb m_next = (reg_wr && reg_addr == 8'h04) ? reg_wdata[3:0] : m_reg;
    always_ff @(posedge mclk or posedge rst)
        if (rst) m_reg <= 4'h0;
        else m_reg <= m_next;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    chk_mask_read: assert property (reg_rd && reg_addr == 8'h04
        |=> reg_rdata == {28'h0, $past(m_reg)}) else $error("mask read");
    chk_state_zero: assert property (rd_st |=> reg_rdata[31:30] == 2'h0
        && reg_rdata[26:14] == 13'h0) else $error("state zeros");
    chk_supply_ones: assert property (rd_st |=> reg_rdata[29:28] == 2'h3)
        else $error("supply bits");
    chk_status_live: assert property ($stable(card_status_change_pin)[*4] ##0 rd_st
        |=> reg_rdata[0] == $past(card_status_change_pin)) else $error("status bit");
    chk_irq_masked: assert property ($past(m_reg) == 4'h0 |-> !status_change_interrupt)
        else $error("masked irq");
    chk_power_irq: assert property (m_reg[3] && $changed(socket_powered_flag)
        |-> ##[1:3] status_change_interrupt) else $error("power irq");
    chk_detect_irq: assert property (m_reg[2:1] == 2'h3 && !card_identifying
        && $changed(card_detect_pin_one) |-> ##[1:5] status_change_interrupt) else $error("cd irq");
    chk_status_irq: assert property (m_reg[0] && !card_is_cardbus
        && $changed(card_status_change_pin) |-> ##[1:5] status_change_interrupt) else $error("st irq");
    cov_irq: cover property ($rose(status_change_interrupt));
    cov_state: cover property (rd_st);
    cov_mask: cover property (reg_wr && reg_addr == 8'h04 && reg_wdata[3:0] == 4'hf);
endmodule // socket_status_mask_regs_properties
`default_nettype wire

// ===== test/socket_status_mask_regs_tb.sv
// bench for the socket status and mask registers
`timescale 1ns/1ns
`default_nettype none
`define CK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("Error %0t: %h not %h", $time, g, e); end end
module socket_status_mask_regs_tb;
    import sock_regs_pkg::*;
    logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, present = 0, csts = 0, rdy = 0;
    logic socket_powered_flag = 0, card_is_cardbus = 0, card_identifying = 0;
    logic card_inserted_pulse = 0, status_change_interrupt, ready_pin;
    logic card_detect_pin_one, card_detect_pin_two, card_status_change_pin;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [2:0] volt = 3'h0, card_volt_sense;
    int failures = 0, checked = 0;
    socket_status_mask_regs dut (.*);
    card_model card (.*);
    initial forever #5 mclk = ~mclk;
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 0;
        reg_rd <= 0;
        @(posedge mclk);
        if (!w) `CK(reg_rdata, d)
    endtask
    task automatic irq(input logic e);
        @(negedge mclk);
        for (int i = 0; i < 8 && status_change_interrupt !== e; i++) @(negedge mclk);
        `CK(status_change_interrupt, e)
        if (status_change_interrupt !== e) give_verdict();
        @(posedge mclk);
    endtask
    task automatic give_verdict;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 0;
        repeat (6) @(posedge mclk);
        acc(1, OFS_EVENT, 32'hf);
        acc(0, OFS_EVENT, 32'h0);
        acc(0, OFS_MASK, MASK_RESET);
        acc(0, OFS_STATE, 32'h3000_0006);
        acc(1, OFS_MASK, 32'hffff_ffff);
        acc(0, OFS_MASK, 32'hf);
        acc(1, OFS_MASK, 32'h0);
        socket_powered_flag <= 1;
        repeat (6) @(posedge mclk);
        `CK(status_change_interrupt, 1'b0)
        acc(0, OFS_EVENT, 32'h8);
        acc(1, OFS_EVENT, 32'h8);
        acc(0, OFS_EVENT, 32'h0);
        acc(1, OFS_MASK, 32'h8);
        socket_powered_flag <= 0;
        irq(1);
        acc(1, OFS_EVENT, 32'h8);
        irq(0);
        $display("test mask and power done");
        acc(1, OFS_MASK, 32'h6);
        card_identifying <= 1;
        present <= 1;
        volt <= 3'h5;
        repeat (6) @(posedge mclk);
        acc(0, OFS_STATE, 32'h3000_0006);
        card_identifying <= 0;
        card_inserted_pulse <= 1;
        @(posedge mclk);
        card_inserted_pulse <= 0;
        irq(1);
        volt <= 3'h2;
        repeat (6) @(posedge mclk);
        acc(0, OFS_STATE, 32'h3000_2800);
        acc(1, OFS_EVENT, 32'h6);
        irq(0);
        $display("test insertion done");
        acc(1, OFS_MASK, 32'h1);
        csts <= 1;
        irq(1);
        acc(1, OFS_EVENT, 32'h1);
        irq(0);
        csts <= 0;
        irq(1);
        acc(1, OFS_EVENT, 32'h1);
        irq(0);
        card_is_cardbus <= 1;
        csts <= 1;
        irq(1);
        acc(1, OFS_EVENT, 32'h1);
        irq(0);
        csts <= 0;
        repeat (6) @(posedge mclk);
        acc(0, OFS_EVENT, 32'h0);
        $display("test status pin done");
        acc(1, OFS_MASK, 32'h6);
        present <= 0;
        irq(1);
        acc(1, OFS_EVENT, 32'h6);
        acc(1, OFS_FORCE, 32'h0800_1002);
        acc(0, OFS_EVENT, 32'h2);
        acc(0, OFS_STATE, 32'h3800_1006);
        $display("test removal and force done");
        give_verdict();
    end
endmodule // socket_status_mask_regs_tb
bind socket_status_mask_regs socket_status_mask_regs_properties chk (.*);
`default_nettype wire
